// ==== wit_defs.svh ====
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH
// Contract
// - interval select codes 001,010,011,101,110,111 pick 2^12..2^17 times two subclock periods.
// - writing one to the counter clear bit loads all prescaler counter bits with one.
// - the counter clear bit reads as zero and writing zero to it does nothing.
// - a software counter clear also clears the watchdog when it runs from this prescaler.
// - the interval flag sets on expiry except in stop mode entered from subclock operation.
// - interrupt request 20 is raised while the interval flag and its enable are both one.
// - the interval flag sets on expiry whatever the enable bit holds.
// - enabling while the flag is already one raises the request at once.
// - a clear in the same cycle as the selected bit overflows suppresses that flag set.
// - writing zero clears the interval flag, writing one is ignored, a modify read returns one.
// - after a clear the counter counts down from all ones at subclock/2 and wraps.

// register byte addresses
`define WIT_ADDR_CTRL 8'h00
`define WIT_ADDR_RMW 8'h04
`define WIT_ADDR_STAT 8'h08
`define WIT_ADDR_MASK 8'h0c
`define WIT_ADDR_MODE 8'h10
// control field positions
`define WIT_BIT_FLAG 7
`define WIT_BIT_IE 6
`define WIT_SEL_HI 3
`define WIT_SEL_LO 1
`define WIT_BIT_CLR 0
// mode register bits
`define WIT_MODE_WDT_SRC 0
`define WIT_MODE_SUB_STOP 1
// reset values
`define WIT_CTRL_RESET 8'h00
`define WIT_CNT_ONES 16'hffff
// axi responses
`define WIT_RESP_OKAY 2'b00
`define WIT_RESP_SLVERR 2'b10
`endif

// ==== wit_pkg.sv ====
package wit_pkg;
    typedef enum logic [1:0] {
        WIT_IDLE = 2'b00,
        WIT_RESP = 2'b01
    } wit_bus_state_t;
    typedef logic [2:0] wit_sel_t;
endpackage

// ==== wit_edge.sv ====
`timescale 1ns/1ns
// rising edge detector for one selected tap, synchronous to CLK
module wit_edge (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic d,
    output logic rise
);
    logic prev;
    logic next_prev;
    // remember last tap value
    always_comb begin
        next_prev = d;
    end
    // the counter resets to all ones, so the tap idles high: no false edge after reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            prev <= 1'b1;
        end else begin
            prev <= next_prev;
        end
    end
    assign rise = d & ~prev;
endmodule

// ==== wit_timer.sv ====
`timescale 1ns/1ns
`include "wit_defs.svh"
// interval timer with axi4-lite registers
module wit_timer #(
    parameter int CNT_W = 18
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SUBCLK_TICK,
    input wire logic SUB_STOP_MODE,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic IRQ20,
    output logic WDT_CLEAR,
    output logic INTR
);
    initial begin
        if (CNT_W < 18) $error("CNT_W must be at least 18");
    end

    // counter bit 0 toggles at subclock/2, so bit n is 2^(n+1) times two subclock periods
    logic [CNT_W-1:0] cnt, next_cnt;
    logic flag, next_flag;
    logic ie, next_ie;
    wit_pkg::wit_sel_t sel, next_sel;
    logic mask, next_mask;
    logic stat, next_stat;
    logic wdt_src, next_wdt_src;
    logic stop_sw, next_stop_sw;
    logic irq, next_irq;
    logic counter_clear_bit, next_counter_clear_bit;
    logic clr_q, next_clr_q;
    logic tap, expire, stop_now;
    logic [4:0] tap_idx;

    // bus state
    wit_pkg::wit_bus_state_t wst, next_wst, rst_st, next_rst_st;
    logic aw_ok, next_aw_ok, w_ok, next_w_ok;
    logic [7:0] awa, next_awa;
    logic [31:0] wd, next_wd;
    logic [3:0] ws, next_ws;
    logic awready, next_awready, wready, next_wready;
    logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic do_wr;

    // interval tap selection, codes 000/100 are the shorter intervals
    always_comb begin
        case (sel)
            3'b100: tap_idx = 5'd9;
            3'b000: tap_idx = 5'd10;
            3'b001: tap_idx = 5'd11;
            3'b010: tap_idx = 5'd12;
            3'b011: tap_idx = 5'd13;
            3'b101: tap_idx = 5'd14;
            3'b110: tap_idx = 5'd15;
            3'b111: tap_idx = 5'd16;
            default: tap_idx = 5'd16;
        endcase
    end
    // down-counter overflow of the tap is its rising edge after a wrap through zero
    assign tap = cnt[tap_idx];
    wit_edge u_edge (
        .CLK(CLK),
        .RESET(RESET),
        .d(tap),
        .rise(expire)
    );
    assign stop_now = SUB_STOP_MODE | stop_sw;
    assign do_wr = aw_ok & w_ok & ~bvalid;

    // core timer state
    always_comb begin
        next_cnt = cnt;
        next_flag = flag;
        next_ie = ie;
        next_sel = sel;
        next_mask = mask;
        next_stat = stat;
        next_wdt_src = wdt_src;
        next_stop_sw = stop_sw;
        next_counter_clear_bit = 1'b0;
        next_clr_q = 1'b0;
        if (SUBCLK_TICK && !stop_now) begin
            next_cnt = cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (do_wr && ws[0]) begin
            case (awa)
                `WIT_ADDR_CTRL, `WIT_ADDR_RMW: begin
                    next_ie = wd[`WIT_BIT_IE];
                    next_sel = wd[`WIT_SEL_HI:`WIT_SEL_LO];
                    if (!wd[`WIT_BIT_FLAG]) next_flag = 1'b0;
                    if (wd[`WIT_BIT_CLR]) begin
                        next_cnt = {CNT_W{1'b1}};
                        next_clr_q = 1'b1;
                        next_counter_clear_bit = wdt_src;
                    end
                end
                `WIT_ADDR_STAT: if (wd[0]) next_stat = 1'b0;
                `WIT_ADDR_MASK: next_mask = wd[0];
                `WIT_ADDR_MODE: begin
                    next_wdt_src = wd[`WIT_MODE_WDT_SRC];
                    next_stop_sw = wd[`WIT_MODE_SUB_STOP];
                end
                default: next_cnt = next_cnt;
            endcase
        end
        // set wins over clear; a simultaneous counter clear suppresses it
        // the tap jump to one on the reload right after a clear is no expiry
        if (expire && !clr_q && !stop_now && !(do_wr && ws[0] && wd[`WIT_BIT_CLR] &&
            (awa == `WIT_ADDR_CTRL || awa == `WIT_ADDR_RMW))) begin
            next_flag = 1'b1;
            next_stat = 1'b1;
        end
        next_irq = next_flag & next_ie;
    end
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cnt <= '1;
            flag <= 1'b0;
            ie <= 1'b0;
            sel <= 3'b000;
            mask <= 1'b0;
            stat <= 1'b0;
            wdt_src <= 1'b0;
            stop_sw <= 1'b0;
            irq <= 1'b0;
            counter_clear_bit <= 1'b0;
            clr_q <= 1'b1;
        end else begin
            cnt <= next_cnt;
            flag <= next_flag;
            ie <= next_ie;
            sel <= next_sel;
            mask <= next_mask;
            stat <= next_stat;
            wdt_src <= next_wdt_src;
            stop_sw <= next_stop_sw;
            irq <= next_irq;
            counter_clear_bit <= next_counter_clear_bit;
            clr_q <= next_clr_q;
        end
    end

    // axi4-lite write and read channels
    always_comb begin
        next_aw_ok = aw_ok;
        next_w_ok = w_ok;
        next_awa = awa;
        next_wd = wd;
        next_ws = ws;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_wst = wst;
        next_awready = 1'b0;
        next_wready = 1'b0;
        if (AWVALID && awready) begin
            next_aw_ok = 1'b1;
            next_awa = AWADDR;
        end else if (!aw_ok && !bvalid && AWVALID) begin
            next_awready = 1'b1;
        end
        if (WVALID && wready) begin
            next_w_ok = 1'b1;
            next_wd = WDATA;
            next_ws = WSTRB;
        end else if (!w_ok && !bvalid && WVALID) begin
            next_wready = 1'b1;
        end
        if (do_wr) begin
            next_aw_ok = 1'b0;
            next_w_ok = 1'b0;
            next_bvalid = 1'b1;
            next_wst = wit_pkg::WIT_RESP;
            next_bresp = (awa <= `WIT_ADDR_MODE && awa[1:0] == 2'b00) ?
                `WIT_RESP_OKAY : `WIT_RESP_SLVERR;
        end else if (bvalid && BREADY) begin
            next_bvalid = 1'b0;
            next_wst = wit_pkg::WIT_IDLE;
        end
        next_rst_st = rst_st;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_arready = !rvalid && !arready && ARVALID;
        if (ARVALID && arready) begin
            next_rvalid = 1'b1;
            next_rst_st = wit_pkg::WIT_RESP;
            next_rresp = `WIT_RESP_OKAY;
            case (ARADDR)
                `WIT_ADDR_CTRL: next_rdata = {24'h000000, flag, ie, 2'b00, sel, 1'b0};
                `WIT_ADDR_RMW: next_rdata = {24'h000000, 1'b1, ie, 2'b00, sel, 1'b0};
                `WIT_ADDR_STAT: next_rdata = {31'h00000000, stat};
                `WIT_ADDR_MASK: next_rdata = {31'h00000000, mask};
                `WIT_ADDR_MODE: next_rdata = {30'h00000000, stop_sw, wdt_src};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `WIT_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && RREADY) begin
            next_rvalid = 1'b0;
            next_rst_st = wit_pkg::WIT_IDLE;
        end
    end
    always_ff @(posedge CLK) begin
        if (RESET) begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            awa <= 8'h00;
            wd <= 32'h00000000;
            ws <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= 2'b00;
            rdata <= 32'h00000000;
            wst <= wit_pkg::WIT_IDLE;
            rst_st <= wit_pkg::WIT_IDLE;
        end else begin
            aw_ok <= next_aw_ok;
            w_ok <= next_w_ok;
            awa <= next_awa;
            wd <= next_wd;
            ws <= next_ws;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            wst <= next_wst;
            rst_st <= next_rst_st;
        end
    end

    // interrupt line from sticky status and mask
    logic intr, next_intr;
    always_comb begin
        next_intr = next_stat & next_mask;
    end
    always_ff @(posedge CLK) begin
        if (RESET) intr <= 1'b0;
        else intr <= next_intr;
    end

    assign AWREADY = awready;
    assign WREADY = wready;
    assign BVALID = bvalid;
    assign BRESP = bresp;
    assign ARREADY = arready;
    assign RVALID = rvalid;
    assign RRESP = rresp;
    assign RDATA = rdata;
    assign IRQ20 = irq;
    assign WDT_CLEAR = counter_clear_bit;
    assign INTR = intr;

    // checks
    property p_irq;
        @(posedge CLK) disable iff (RESET) 1'b1 |-> (IRQ20 == (flag & ie));
    endproperty
    a_irq: assert property (p_irq) else $error("irq not flag and enable");
    property p_clr;
        @(posedge CLK) disable iff (RESET)
            (do_wr && ws[0] && awa == `WIT_ADDR_CTRL && wd[0]) |=> (cnt == {CNT_W{1'b1}});
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not load ones");
    property p_rd0;
        @(posedge CLK) disable iff (RESET)
            (ARVALID && arready && (ARADDR == `WIT_ADDR_CTRL || ARADDR == `WIT_ADDR_RMW))
            |=> (RDATA[0] == 1'b0);
    endproperty
    a_rd0: assert property (p_rd0) else $error("clear bit read nonzero");
    property p_wdt;
        @(posedge CLK) disable iff (RESET)
            (do_wr && ws[0] && awa == `WIT_ADDR_CTRL && wd[0] && wdt_src) |=> WDT_CLEAR;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog not cleared");
    property p_set;
        @(posedge CLK) disable iff (RESET) (expire && !clr_q && !stop_now && !do_wr) |=> flag;
    endproperty
    a_set: assert property (p_set) else $error("flag not set on expiry");
    property p_stop;
        @(posedge CLK) disable iff (RESET) (stop_now && !flag && !do_wr) |=> !flag;
    endproperty
    a_stop: assert property (p_stop) else $error("flag set in stop");
    property p_en;
        @(posedge CLK) disable iff (RESET) (flag && $rose(ie)) |-> ##1 IRQ20;
    endproperty
    a_en: assert property (p_en) else $error("late irq on enable");
    property p_sup;
        @(posedge CLK) disable iff (RESET)
            (expire && !flag && do_wr && ws[0] && awa == `WIT_ADDR_CTRL && wd[0]) |=> !flag;
    endproperty
    a_sup: assert property (p_sup) else $error("flag set despite clear");
    property p_w1;
        @(posedge CLK) disable iff (RESET) (!flag && !expire) |=> !flag;
    endproperty
    a_w1: assert property (p_w1) else $error("flag set without expiry");
endmodule

// ==== wit_partner.sv ====
`timescale 1ns/1ns
// far side: interrupt controller and watchdog, counting what reaches them
module wit_partner (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic IRQ20,
    input wire logic WDT_CLEAR,
    output logic [7:0] n_wdt,
    output logic [7:0] n_irq
);
    logic irq_q;
    // watchdog restarts and newly raised requests
    always_ff @(posedge CLK) begin
        if (RESET) begin
            n_wdt <= 8'h00;
            n_irq <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            irq_q <= IRQ20;
            if (WDT_CLEAR) n_wdt <= n_wdt + 8'h01;
            if (IRQ20 && !irq_q) n_irq <= n_irq + 8'h01;
        end
    end
endmodule

// ==== watch_interval_timer_tb.sv ====
`timescale 1ns/1ns
`include "wit_defs.svh"
// self-checking bench for the interval timer
module watch_interval_timer_tb;
    logic CLK = 1'b0;
    logic RESET, SUBCLK_TICK, SUB_STOP_MODE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic [7:0] AWADDR, ARADDR, n_wdt, n_irq;
    logic [31:0] WDATA, RDATA, d;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, r;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ20, WDT_CLEAR, INTR;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;

    wit_timer #(.CNT_W(18)) i_dut (.CLK(CLK), .RESET(RESET), .SUBCLK_TICK(SUBCLK_TICK),
        .SUB_STOP_MODE(SUB_STOP_MODE), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .IRQ20(IRQ20), .WDT_CLEAR(WDT_CLEAR), .INTR(INTR));
    wit_partner i_far (.CLK(CLK), .RESET(RESET), .IRQ20(IRQ20), .WDT_CLEAR(WDT_CLEAR),
        .n_wdt(n_wdt), .n_irq(n_irq));

    // 125 MHz clock and cycle ceiling
    always #4 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 99000) begin
            n_fail++;
            give_verdict;
        end
    end

    task give_verdict;
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge CLK);
    endtask

    function automatic logic [31:0] cw(logic f, logic ie, logic [2:0] s, logic c);
        return {24'h000000, f, ie, 2'b00, s, c};
    endfunction

    // one write, both channels offered together, ready lines always high
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic b;
        b = 1'b0;
        AWADDR <= a;
        WDATA <= v;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (!b) begin
            @(posedge CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1) begin
                b = 1'b1;
                r = BRESP;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic b;
        b = 1'b0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        while (!b) begin
            @(posedge CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) begin
                b = 1'b1;
                d = RDATA;
                r = RRESP;
            end
        end
    endtask

    // reset value and unmapped place
    task t_reset;
        rd(`WIT_ADDR_CTRL);
        chk(d, {24'h000000, `WIT_CTRL_RESET});
        rd(8'h20);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `WIT_RESP_SLVERR});
        wr(8'h20, 32'h1);
        chk(r, `WIT_RESP_SLVERR);
    endtask

    // flag with enable off, late enable, service clear, read views
    task t_flag;
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 1));
        wt(1100);
        chk(IRQ20, 0);
        rd(`WIT_ADDR_CTRL);
        chk(d[7], 1);
        wr(`WIT_ADDR_CTRL, cw(1, 1, 3'h4, 0));
        wt(2);
        chk(IRQ20, 1);
        wt(1100);
        chk(IRQ20, 1);
        wr(`WIT_ADDR_CTRL, cw(0, 1, 3'h4, 1));
        wt(2);
        chk(IRQ20, 0);
        rd(`WIT_ADDR_CTRL);
        chk(d, cw(0, 1, 3'h4, 0));
        rd(`WIT_ADDR_RMW);
        chk(d, cw(1, 1, 3'h4, 0));
        wr(`WIT_ADDR_CTRL, cw(1, 1, 3'h4, 0));
        rd(`WIT_ADDR_CTRL);
        chk(d, cw(0, 1, 3'h4, 0));
        chk(n_irq, 8'h01);
    endtask

    // no flag while stopped from subclock, counting resumes after
    task t_stop;
        SUB_STOP_MODE <= 1'b1;
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 1));
        wt(1100);
        rd(`WIT_ADDR_CTRL);
        chk(d[7], 0);
        SUB_STOP_MODE <= 1'b0;
        wt(1100);
        rd(`WIT_ADDR_CTRL);
        chk(d[7], 1);
        // software stop bit freezes the counter as the pin does
        wr(`WIT_ADDR_MODE, 32'h2);
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 1));
        wt(1100);
        rd(`WIT_ADDR_MODE);
        chk(d, 32'h2);
        rd(`WIT_ADDR_CTRL);
        chk(d[7], 0);
        wr(`WIT_ADDR_MODE, 32'h0);
    endtask

    // sticky status, mask and level output
    task t_irq;
        wr(`WIT_ADDR_MASK, 32'h1);
        wr(`WIT_ADDR_STAT, 32'h1);
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 1));
        wt(1100);
        chk(INTR, 1);
        rd(`WIT_ADDR_STAT);
        chk(d, 32'h1);
        wr(`WIT_ADDR_MASK, 32'h0);
        wt(2);
        chk(INTR, 0);
        wr(`WIT_ADDR_MASK, 32'h1);
        wt(2);
        chk(INTR, 1);
        wr(`WIT_ADDR_STAT, 32'h1);
        wt(2);
        chk(INTR, 0);
        rd(`WIT_ADDR_STAT);
        chk(d, 32'h0);
    endtask

    // watchdog restart follows its source, repeated clears hold off expiry
    task t_wdt;
        wr(`WIT_ADDR_MODE, 32'h1);
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 1));
        wt(2);
        chk(n_wdt, 8'h01);
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 0));
        wr(`WIT_ADDR_MODE, 32'h0);
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 1));
        wt(2);
        chk(n_wdt, 8'h01);
        repeat (3) begin
            wt(700);
            wr(`WIT_ADDR_CTRL, cw(1, 0, 3'h4, 1));
        end
        rd(`WIT_ADDR_CTRL);
        chk(d[7], 0);
        // second clear is taken in the very cycle the tap overflows
        wr(`WIT_ADDR_CTRL, cw(0, 0, 3'h4, 1));
        wt(1021);
        wr(`WIT_ADDR_CTRL, cw(1, 0, 3'h4, 1));
        rd(`WIT_ADDR_CTRL);
        chk(d[7], 0);
    endtask

    // every select code: 000-100 timed from the clear, 101-111 only checked quiet for 16400 cycles
    task automatic t_intervals;
        logic [2:0] sel [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h5, 3'h6, 3'h7};
        int nx [8] = '{4096, 8192, 16384, 1024, 2048, 32768, 65536, 131072};
        int c;
        int lim;
        for (int i = 0; i < 8; i++) begin
            wr(`WIT_ADDR_CTRL, cw(0, 1, sel[i], 1));
            wt(2);
            c = 2;
            lim = (i < 5) ? nx[i] + 8 : 16400;
            while (IRQ20 !== 1'b1 && c < lim) begin
                @(posedge CLK);
                c++;
            end
            if (i < 5) chk(c >= nx[i] - 6 && c <= nx[i] + 4, 1);
            else chk(IRQ20, 0);
        end
    endtask

    // reset, then the scenarios in turn
    initial begin
        RESET = 1'b1;
        SUBCLK_TICK = 1'b0;
        SUB_STOP_MODE = 1'b0;
        AWADDR = 8'h00;
        ARADDR = 8'h00;
        WDATA = 32'h0;
        WSTRB = 4'hf;
        AWVALID = 1'b0;
        WVALID = 1'b0;
        ARVALID = 1'b0;
        BREADY = 1'b1;
        RREADY = 1'b1;
        wt(8);
        RESET <= 1'b0;
        SUBCLK_TICK <= 1'b1;
        wt(1);
        t_reset;
        t_flag;
        t_stop;
        t_irq;
        t_wdt;
        t_intervals;
        give_verdict;
    end
endmodule
